// *** verilog/dp_pkg.sv ***
package dp_pkg;

	// Widths of the register space
	localparam int DP_DATA_W = 9;
	localparam int DP_ADDR_W = 4;
	localparam int DP_NIB_W  = 4;
	localparam int DP_NETS   = 2;

	// Register addresses
	localparam logic [3:0] DP_ADDR_WIPER0 = 4'h0;
	localparam logic [3:0] DP_ADDR_WIPER1 = 4'h1;
	localparam logic [3:0] DP_ADDR_TERMINAL_CONNECT_CONTROL   = 4'h4;
	localparam logic [3:0] DP_ADDR_STATUS = 4'h5;

	// Reset and read values
	localparam logic [8:0] DP_WIPER_MID_8BIT = 9'h080;
	localparam logic [8:0] DP_WIPER_MID_7BIT = 9'h040;
	localparam logic [8:0] DP_TERMINAL_CONNECT_CONTROL_RESET     = 9'h1FF;
	localparam logic [8:0] DP_RSVD_READ      = 9'h000;
	localparam logic [3:0] DP_STATUS_ONES    = 4'hF;

	// Field positions
	localparam int DP_TERMINAL_CONNECT_CONTROL_RSVD_BIT = 8;
	localparam int DP_ST_ONES_LSB   = 5;
	localparam int DP_ST_HW_POWERDOWN_PIN_N_BIT   = 1;

	// One network's control nibble, bit 3 down to bit 0
	typedef struct packed {
		logic hw_n;
		logic a;
		logic w;
		logic b;
	} dp_terminal_connect_control_nib_s;

	// Terminal switch state of one network
	typedef struct packed {
		logic a;
		logic w;
		logic b;
		logic w_to_b;
	} dp_switch_s;

	// One completed serial command
	typedef struct packed {
		logic       write;
		logic [3:0] addr;
		logic [8:0] wdata;
	} dp_cmd_s;

	localparam dp_switch_s DP_SW_SHUTDOWN = '{a: 1'b0, w: 1'b1, b: 1'b1, w_to_b: 1'b1};
	localparam dp_switch_s DP_SW_RESET    = '{a: 1'b1, w: 1'b1, b: 1'b1, w_to_b: 1'b0};

endpackage : dp_pkg

// *** verilog/dp_net_switch.sv ***
module dp_net_switch
	import dp_pkg::*;
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// Control
	input  dp_terminal_connect_control_nib_s      ctl,
	input  wire logic         hw_powerdown_pin_n,
	// Switches
	output dp_switch_s        sw
);

	logic forced;

	// Pin or force bit selects the shutdown arrangement
	assign forced = !ctl.hw_n || !hw_powerdown_pin_n;

	// Switch state, registered
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sw <= DP_SW_RESET;
		end else if (forced) begin
			sw <= DP_SW_SHUTDOWN;
		end else begin
			sw <= '{a: ctl.a, w: ctl.w, b: ctl.b, w_to_b: 1'b0};
		end
	end

	AST_FORCE_BIT: assert property (@(posedge clk) disable iff (!reset_n)
		!ctl.hw_n |=> sw == DP_SW_SHUTDOWN)
		else $error("force bit low did not give shutdown arrangement");

	AST_PLAIN_BITS: assert property (@(posedge clk) disable iff (!reset_n)
		(ctl.hw_n && hw_powerdown_pin_n) |=>
		(sw.a == $past(ctl.a)) && (sw.w == $past(ctl.w)) && (sw.b == $past(ctl.b))
		&& !sw.w_to_b)
		else $error("terminal switches do not follow control bits");

endmodule : dp_net_switch

// *** verilog/dp_regmap.sv ***
// Notes on behaviour
// - Leaving reset loads default wipers, then the command port opens.
// - Reset sets terminal control to all ones, every terminal connected.
// - While held in reset no command is accepted.
// - Space is sixteen nine-bit locations; unassigned ones are reserved.
// - Wiper 0 at 0h, wiper 1 at 1h when dual; 2h, 3h, 6h-Fh reserved.
// - Status sits at 5h and can only be read.
// - Status bits 8..5 read one; bits 4..2 and 0 reserved, read zero.
// - Status bit 1 reads one while the shutdown pin is low.
// - Commands keep working during hardware shutdown.
// - Terminal control: bits 7:4 network 1, 3:0 network 0, bit 8 reads one.
// - Force bit at zero puts its network into shutdown arrangement.
// - Terminal A connect bit: one connects, zero disconnects.
// - Wiper connect bit: one connects, zero disconnects.
// - Terminal B connect bit: one connects, zero disconnects.
// - New terminal control reaches switches only after the write completes.
// - Shutdown pin overrides control bits but leaves them stored.
// - Terminal control writes never touch the wiper registers.
// - Shutdown disconnects terminal A and joins wiper to terminal B.
// - Default wiper is mid-scale: 80h for 8-bit, 40h for 7-bit.
module dp_regmap
	import dp_pkg::*;
#(
	parameter bit RES_8BIT = 1'b1,
	parameter bit DUAL     = 1'b1
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	// Command port
	input  wire logic                 cmd_valid,
	input  dp_cmd_s                   cmd,
	output logic                      cmd_ready,
	// Response port
	output logic                      rsp_valid,
	output logic [DP_DATA_W-1:0]      rsp_data,
	output logic                      rsp_err,
	// Shutdown pin
	input  wire logic                 hw_powerdown_pin_n,
	// Network outputs
	output logic [DP_DATA_W-1:0]      wiper0_value,
	output logic [DP_DATA_W-1:0]      wiper1_value,
	output dp_switch_s [DP_NETS-1:0]  net_switch
);

	localparam logic [8:0] WIPER_DEF = RES_8BIT ? DP_WIPER_MID_8BIT : DP_WIPER_MID_7BIT;

	logic                  ready;
	logic                  accept;
	logic                  wr_wiper0;
	logic                  wr_wiper1;
	logic                  wr_terminal_connect_control;
	logic [7:0]            terminal_connect_control_ctl;
	logic [DP_DATA_W-1:0]  terminal_connect_control_read;
	logic [DP_DATA_W-1:0]  status_read;
	logic [DP_DATA_W-1:0]  next_rsp_data;
	logic                  next_rsp_err;
	logic                  hw_powerdown_pin_n_active;
	dp_terminal_connect_control_nib_s [DP_NETS-1:0] nib_ctl;

	// Open the port one edge after reset release
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ready <= 1'b0;
		end else begin
			ready <= 1'b1;
		end
	end

	// Port is shut only by reset, not by the shutdown pin
	assign cmd_ready = ready;
	assign accept    = cmd_valid && ready;

	// Write decode
	assign wr_wiper0 = accept && cmd.write && (cmd.addr == DP_ADDR_WIPER0);
	assign wr_wiper1 = accept && cmd.write && (cmd.addr == DP_ADDR_WIPER1) && DUAL;
	assign wr_terminal_connect_control   = accept && cmd.write && (cmd.addr == DP_ADDR_TERMINAL_CONNECT_CONTROL);

	// Wiper 0 register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wiper0_value <= WIPER_DEF;
		end else if (wr_wiper0) begin
			wiper0_value <= cmd.wdata;
		end
	end

	// Wiper 1 register, fixed when single network
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wiper1_value <= DUAL ? WIPER_DEF : DP_RSVD_READ;
		end else if (wr_wiper1) begin
			wiper1_value <= cmd.wdata;
		end
	end

	// Terminal control register; only written by a command
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			terminal_connect_control_ctl <= DP_TERMINAL_CONNECT_CONTROL_RESET[7:0];
		end else if (wr_terminal_connect_control) begin
			terminal_connect_control_ctl <= cmd.wdata[7:0];
		end
	end

	// Read images of terminal control and status
	assign hw_powerdown_pin_n_active = !hw_powerdown_pin_n;

	always_comb begin
		terminal_connect_control_read                   = {1'b0, terminal_connect_control_ctl};
		terminal_connect_control_read[DP_TERMINAL_CONNECT_CONTROL_RSVD_BIT] = 1'b1;
	end

	always_comb begin
		status_read                          = DP_RSVD_READ;
		status_read[DP_ST_ONES_LSB +: $bits(DP_STATUS_ONES)] = DP_STATUS_ONES;
		status_read[DP_ST_HW_POWERDOWN_PIN_N_BIT]          = hw_powerdown_pin_n_active;
	end

	// Response contents by address
	always_comb begin
		next_rsp_data = DP_RSVD_READ;
		next_rsp_err  = 1'b0;
		case (cmd.addr)
			DP_ADDR_WIPER0: begin
				next_rsp_data = wiper0_value;
			end
			DP_ADDR_WIPER1: begin
				next_rsp_data = wiper1_value;
				next_rsp_err  = !DUAL;
			end
			DP_ADDR_TERMINAL_CONNECT_CONTROL: begin
				next_rsp_data = terminal_connect_control_read;
			end
			DP_ADDR_STATUS: begin
				next_rsp_data = status_read;
				next_rsp_err  = cmd.write;
			end
			default: begin
				next_rsp_err  = 1'b1;
			end
		endcase
	end

	// Response pulse one edge after acceptance
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rsp_valid <= 1'b0;
		end else begin
			rsp_valid <= accept;
		end
	end

	// Response data and error, held until next command
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rsp_data <= DP_RSVD_READ;
			rsp_err  <= 1'b0;
		end else if (accept) begin
			rsp_data <= cmd.write ? DP_RSVD_READ : next_rsp_data;
			rsp_err  <= next_rsp_err;
		end
	end

	// Control bits seen as one nibble per network
	assign nib_ctl = terminal_connect_control_ctl;

	// Terminal switches per network, from the stored bits
	genvar n;
	generate
		for (n = 0; n < DP_NETS; n++) begin : g_net
			if (n == 0 || DUAL) begin : g_on
				dp_net_switch u_dp_net_switch (
					.clk                (clk),
					.reset_n            (reset_n),
					.ctl                (nib_ctl[n]),
					.hw_powerdown_pin_n (hw_powerdown_pin_n),
					.sw                 (net_switch[n])
				);
			end else begin : g_off
				assign net_switch[n] = '0;
			end
		end
	endgenerate

	// Checks

	AST_RESET_WIPER: assert property (@(posedge clk) disable iff (!reset_n)
		(ready && !$past(ready)) |-> (wiper0_value == WIPER_DEF))
		else $error("wiper not at mid-scale when port opened");

	AST_RESET_TERMINAL_CONNECT_CONTROL: assert property (@(posedge clk) disable iff (!reset_n)
		(ready && !$past(ready)) |-> (terminal_connect_control_read == DP_TERMINAL_CONNECT_CONTROL_RESET))
		else $error("terminal control not all ones after reset");

	AST_PORT_SHUT: assert property (@(posedge clk) disable iff (!reset_n)
		!ready |-> !cmd_ready ##1 cmd_ready)
		else $error("port state wrong around reset release");

	AST_HW_POWERDOWN_PIN_N_PORT: assert property (@(posedge clk) disable iff (!reset_n)
		(ready && !hw_powerdown_pin_n && cmd_valid) |=> rsp_valid)
		else $error("command dropped during hardware shutdown");

	AST_STATUS_READ: assert property (@(posedge clk) disable iff (!reset_n)
		(accept && !cmd.write && cmd.addr == DP_ADDR_STATUS) |=>
		rsp_data == {DP_STATUS_ONES, 3'h0, !$past(hw_powerdown_pin_n), 1'h0})
		else $error("status read value wrong");

	AST_STATUS_RO: assert property (@(posedge clk) disable iff (!reset_n)
		(accept && cmd.write && cmd.addr == DP_ADDR_STATUS) |=>
		rsp_err && $stable(terminal_connect_control_ctl) && $stable(wiper0_value) && $stable(wiper1_value))
		else $error("status write changed state or gave no error");

	AST_RSVD_READ: assert property (@(posedge clk) disable iff (!reset_n)
		(accept && !cmd.write && (cmd.addr inside {4'h2, 4'h3} || cmd.addr > 4'h5))
		|=> rsp_err && (rsp_data == DP_RSVD_READ))
		else $error("reserved read not zero with error");

	AST_TERMINAL_CONNECT_CONTROL_LATE: assert property (@(posedge clk) disable iff (!reset_n)
		(wr_terminal_connect_control && hw_powerdown_pin_n && cmd.wdata[3]) ##1 hw_powerdown_pin_n |=>
		net_switch[0].a == $past(cmd.wdata[2], 2))
		else $error("written terminal bit did not reach switch");

	AST_TERMINAL_CONNECT_CONTROL_STORE: assert property (@(posedge clk) disable iff (!reset_n)
		wr_terminal_connect_control |=> terminal_connect_control_read == {1'b1, $past(cmd.wdata[7:0])})
		else $error("terminal control write not stored");

	AST_HW_POWERDOWN_PIN_N_CFG: assert property (@(posedge clk) disable iff (!reset_n)
		!hw_powerdown_pin_n |=> !net_switch[0].a && net_switch[0].w_to_b)
		else $error("pin shutdown arrangement wrong");

	AST_HW_POWERDOWN_PIN_N_KEEP: assert property (@(posedge clk) disable iff (!reset_n)
		(!hw_powerdown_pin_n && !wr_terminal_connect_control) |=> $stable(terminal_connect_control_ctl))
		else $error("shutdown pin altered terminal control bits");

	AST_WIPER_KEEP: assert property (@(posedge clk) disable iff (!reset_n)
		wr_terminal_connect_control |=> $stable(wiper0_value) && $stable(wiper1_value))
		else $error("terminal control write altered a wiper");

	// Register contents and responses

	AST_RESET_WIPER1: assert property (@(posedge clk) disable iff (!reset_n)
		(ready && !$past(ready)) |-> (wiper1_value == (DUAL ? WIPER_DEF : DP_RSVD_READ)))
		else $error("wiper 1 not at default when port opened");

	AST_RSP_ONLY: assert property (@(posedge clk) disable iff (!reset_n)
		!(cmd_valid && cmd_ready) |=> !rsp_valid)
		else $error("response without an accepted command");

	AST_WIPER0_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
		(accept && cmd.write && cmd.addr == DP_ADDR_WIPER0) |=>
		(wiper0_value == $past(cmd.wdata)) && !rsp_err)
		else $error("wiper 0 write not stored");

	AST_WIPER1_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
		(accept && cmd.write && cmd.addr == DP_ADDR_WIPER1 && DUAL) |=>
		(wiper1_value == $past(cmd.wdata)) && !rsp_err)
		else $error("wiper 1 write not stored");

	AST_WIPER0_READ: assert property (@(posedge clk) disable iff (!reset_n)
		(accept && !cmd.write && cmd.addr == DP_ADDR_WIPER0) |=>
		(rsp_data == $past(wiper0_value)) && !rsp_err)
		else $error("wiper 0 read value wrong");

	AST_WIPER1_READ: assert property (@(posedge clk) disable iff (!reset_n)
		(accept && !cmd.write && cmd.addr == DP_ADDR_WIPER1) |=>
		(rsp_data == $past(wiper1_value)) && (rsp_err == !DUAL))
		else $error("wiper 1 read value wrong");

	AST_TERMINAL_CONNECT_CONTROL_READ: assert property (@(posedge clk) disable iff (!reset_n)
		(accept && !cmd.write && cmd.addr == DP_ADDR_TERMINAL_CONNECT_CONTROL) |=>
		(rsp_data == {1'b1, $past(terminal_connect_control_ctl)}) && !rsp_err)
		else $error("terminal control read value wrong");

	AST_STATUS_NOERR: assert property (@(posedge clk) disable iff (!reset_n)
		(accept && !cmd.write && cmd.addr == DP_ADDR_STATUS) |=> !rsp_err)
		else $error("status read flagged as error");

	AST_STATUS_WDATA: assert property (@(posedge clk) disable iff (!reset_n)
		(accept && cmd.write && cmd.addr == DP_ADDR_STATUS) |=>
		rsp_data == DP_RSVD_READ)
		else $error("status write returned data");

	AST_STATUS_HIGH: assert property (@(posedge clk) disable iff (!reset_n)
		(accept && !cmd.write && cmd.addr == DP_ADDR_STATUS && hw_powerdown_pin_n) |=>
		!rsp_data[DP_ST_HW_POWERDOWN_PIN_N_BIT])
		else $error("status shows shutdown with pin high");

	AST_RSVD_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
		(accept && cmd.write && (cmd.addr inside {4'h2, 4'h3} || cmd.addr > DP_ADDR_STATUS))
		|=> rsp_err && (rsp_data == DP_RSVD_READ) && $stable(terminal_connect_control_ctl)
		&& $stable(wiper0_value) && $stable(wiper1_value))
		else $error("reserved write changed state or gave no error");

	AST_HW_POWERDOWN_PIN_N_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
		(!hw_powerdown_pin_n && wr_wiper1) |=>
		wiper1_value == $past(cmd.wdata))
		else $error("write lost during hardware shutdown");

	AST_WIPER_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
		!(wr_wiper0 || wr_wiper1) |=> $stable(wiper0_value) && $stable(wiper1_value))
		else $error("wiper changed without its own write");

	// Terminal switches

	AST_HW_POWERDOWN_PIN_N_NET0: assert property (@(posedge clk) disable iff (!reset_n)
		!hw_powerdown_pin_n |=> net_switch[0] == DP_SW_SHUTDOWN)
		else $error("network 0 not in shutdown arrangement");

	AST_HW_POWERDOWN_PIN_N_NET1: assert property (@(posedge clk) disable iff (!reset_n)
		(DUAL && !hw_powerdown_pin_n) |=> net_switch[1] == DP_SW_SHUTDOWN)
		else $error("network 1 not in shutdown arrangement");

	AST_NET1_FORCE: assert property (@(posedge clk) disable iff (!reset_n)
		(DUAL && !nib_ctl[1].hw_n) |=> net_switch[1] == DP_SW_SHUTDOWN)
		else $error("network 1 force bit ignored");

	AST_NET1_BITS: assert property (@(posedge clk) disable iff (!reset_n)
		(DUAL && nib_ctl[1].hw_n && hw_powerdown_pin_n) |=>
		(net_switch[1].a == $past(nib_ctl[1].a)) && (net_switch[1].w == $past(nib_ctl[1].w))
		&& (net_switch[1].b == $past(nib_ctl[1].b)) && !net_switch[1].w_to_b)
		else $error("network 1 switches do not follow control bits");

	AST_PIN_RELEASE: assert property (@(posedge clk) disable iff (!reset_n)
		($past(!hw_powerdown_pin_n) && hw_powerdown_pin_n && nib_ctl[0].hw_n) |=>
		(net_switch[0].a == $past(nib_ctl[0].a)) && (net_switch[0].b == $past(nib_ctl[0].b))
		&& !net_switch[0].w_to_b)
		else $error("stored bits not back in control after pin release");

	AST_SWITCH_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
		(ready && (terminal_connect_control_ctl == $past(terminal_connect_control_ctl))
		&& (hw_powerdown_pin_n == $past(hw_powerdown_pin_n))) |=> $stable(net_switch))
		else $error("switches moved with no write and no pin change");

	COV_WIPER_WRITE: cover property (@(posedge clk) disable iff (!reset_n)
		wr_wiper0 ##1 rsp_valid);

	COV_HW_POWERDOWN_PIN_N_STATUS: cover property (@(posedge clk) disable iff (!reset_n)
		(accept && !cmd.write && cmd.addr == DP_ADDR_STATUS && !hw_powerdown_pin_n));

	COV_FORCE_BIT: cover property (@(posedge clk) disable iff (!reset_n)
		wr_terminal_connect_control && !cmd.wdata[3] ##2 net_switch[0].w_to_b);

	COV_PIN_RELEASE: cover property (@(posedge clk) disable iff (!reset_n)
		!hw_powerdown_pin_n ##1 hw_powerdown_pin_n ##1 !net_switch[0].w_to_b);

	COV_NET1_FORCE: cover property (@(posedge clk) disable iff (!reset_n)
		DUAL && !nib_ctl[1].hw_n ##1 net_switch[1].w_to_b);

endmodule : dp_regmap

// *** verif/dp_host_model.sv ***
module dp_host_model
	import dp_pkg::*;
(
	// Clock
	input  wire logic       clk,
	// Command and response port
	input  wire logic       cmd_ready,
	input  wire logic       rsp_valid,
	input  wire logic [8:0] rsp_data,
	input  wire logic       rsp_err,
	output logic            cmd_valid,
	output dp_cmd_s         cmd
);
	timeunit 1ns;
	timeprecision 1ps;

	// Port idle at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
	end

	// One command: wait, hold until taken, release, then collect the answer
	task automatic xfer(input int gap, input dp_cmd_s c, output logic ok,
		output logic [8:0] rd, output logic er);
		repeat (gap + 1) @(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= c;
		do @(posedge clk); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		cmd <= ~c; // Released port shows no stale command
		@(posedge clk);
		ok = rsp_valid;
		rd = rsp_data;
		er = rsp_err;
	endtask : xfer
endmodule : dp_host_model

// *** verif/digipot_volatile_register_map_tb.sv ***
module digipot_volatile_register_map_tb
	import dp_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	logic             clk, reset_n, pin_n, cmd_valid, cmd_ready, rsp_valid, rsp_err;
	dp_cmd_s          cmd;
	logic [8:0]       rsp_data, w0, w1;
	dp_switch_s [1:0] sw;
	int               num_errors = 0;
	int               total_checks = 0;

	dp_regmap u_dp_regmap (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
		.hw_powerdown_pin_n(pin_n), .wiper0_value(w0), .wiper1_value(w1), .net_switch(sw));

	dp_host_model u_dp_host_model (.clk(clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_err(rsp_err), .cmd_valid(cmd_valid), .cmd(cmd));

	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One command through the host, with expected answer
	task automatic acc(input logic wr, input logic [3:0] a, input logic [8:0] d,
		input logic [8:0] ed, input logic ee, input int gap = 0);
		logic       ok, er;
		logic [8:0] rd;
		u_dp_host_model.xfer(gap, '{write: wr, addr: a, wdata: d}, ok, rd, er);
		chk("rsp_valid", 9'h001, {8'h00, ok});
		chk("rsp_data", ed, rd);
		chk("rsp_err", {8'h00, ee}, {8'h00, er});
	endtask : acc

	function automatic dp_switch_s exp_sw(input logic [3:0] n, input logic p);
		if (!n[3] || !p) return DP_SW_SHUTDOWN;
		return '{a: n[2], w: n[1], b: n[0], w_to_b: 1'b0};
	endfunction : exp_sw

	// Let switches settle one edge, then compare both networks
	task automatic chk_sw(input logic [7:0] t);
		@(posedge clk);
		#1;
		chk("net0", {5'h00, exp_sw(t[3:0], pin_n)}, {5'h00, sw[0]});
		chk("net1", {5'h00, exp_sw(t[7:4], pin_n)}, {5'h00, sw[1]});
	endtask : chk_sw

	task automatic set_pin(input logic v);
		@(posedge clk);
		pin_n <= v;
	endtask : set_pin

	// Watchdog far beyond the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		give_verdict();
	end

	// Main sequence
	initial begin
		logic [7:0] t;
		reset_n = 1'b0;
		pin_n = 1'b1;
		repeat (8) @(posedge clk);
		#1;
		chk("ready in reset", 9'h000, {8'h00, cmd_ready});
		chk("wiper0", DP_WIPER_MID_8BIT, w0);
		chk("wiper1", DP_WIPER_MID_8BIT, w1);
		chk("switches", {1'b0, DP_SW_RESET, DP_SW_RESET}, {1'b0, sw});
		@(posedge clk);
		reset_n <= 1'b1;
		acc(1'b0, DP_ADDR_TERMINAL_CONNECT_CONTROL, 9'h000, DP_TERMINAL_CONNECT_CONTROL_RESET, 1'b0);
		acc(1'b0, DP_ADDR_STATUS, 9'h000, 9'h1E0, 1'b0, 3);
		set_pin(1'b0);
		acc(1'b0, DP_ADDR_STATUS, 9'h000, 9'h1E2, 1'b0);
		acc(1'b1, DP_ADDR_STATUS, 9'h1FF, 9'h000, 1'b1);
		acc(1'b1, DP_ADDR_WIPER1, 9'h033, 9'h000, 1'b0);
		chk_sw(8'hFF);
		set_pin(1'b1);
		acc(1'b1, DP_ADDR_WIPER0, 9'h1A5, 9'h000, 1'b0);
		acc(1'b0, DP_ADDR_WIPER1, 9'h000, 9'h033, 1'b0);
		acc(1'b0, DP_ADDR_WIPER0, 9'h000, 9'h1A5, 1'b0);
		// Reserved places refuse writes and read zero
		for (int a = 2; a < 16; a++) begin
			if (a != 4 && a != 5) begin
				acc(1'b1, a[3:0], 9'h1FF, 9'h000, 1'b1);
				acc(1'b0, a[3:0], 9'h000, 9'h000, 1'b1);
			end
		end
		// Every control nibble on both networks, complementary patterns
		for (int i = 0; i < 16; i++) begin
			t = {i[3:0], ~i[3:0]};
			acc(1'b1, DP_ADDR_TERMINAL_CONNECT_CONTROL, {1'b0, t}, 9'h000, 1'b0);
			chk_sw(t);
			acc(1'b0, DP_ADDR_TERMINAL_CONNECT_CONTROL, 9'h000, {1'b1, t}, 1'b0);
			chk("wiper0", 9'h1A5, w0);
			chk("wiper1", 9'h033, w1);
		end
		// Pin overrides the stored bits without altering them
		set_pin(1'b0);
		chk_sw(t);
		acc(1'b0, DP_ADDR_TERMINAL_CONNECT_CONTROL, 9'h000, {1'b1, t}, 1'b0);
		set_pin(1'b1);
		chk_sw(t);
		// Second reset in mid-run
		@(posedge clk);
		reset_n <= 1'b0;
		@(posedge clk);
		#1;
		chk("ready in reset", 9'h000, {8'h00, cmd_ready});
		chk("wiper0", DP_WIPER_MID_8BIT, w0);
		@(posedge clk);
		reset_n <= 1'b1;
		acc(1'b0, DP_ADDR_TERMINAL_CONNECT_CONTROL, 9'h000, DP_TERMINAL_CONNECT_CONTROL_RESET, 1'b0);
		acc(1'b1, DP_ADDR_TERMINAL_CONNECT_CONTROL, 9'h0F7, 9'h000, 1'b0);
		chk_sw(8'hF7);
		give_verdict();
	end
endmodule : digipot_volatile_register_map_tb
